// file: hdl/atsm_regs.vh
/*
  Register map, field layout, reset values and source codes of the auxiliary
  test signal mux. Assumes an Avalon-MM slave with byte addresses, where each
  register index sits in one aligned 32-bit word at byte address index*4.
*/
`ifndef ATSM_REGS_VH
`define ATSM_REGS_VH

// ***************************************************************
// Register indices (byte address is index times four)
// ***************************************************************
`define ATSM_IDX_SRC_SEL   6'h38
`define ATSM_IDX_CONV1     6'h39
`define ATSM_IDX_CONV2     6'h3A
`define ATSM_IDX_SAMPLE    6'h3B
`define ATSM_IDX_PROD      6'h3C

// ***************************************************************
// Field positions
// ***************************************************************
`define ATSM_SEL1_MSB      7
`define ATSM_SEL1_LSB      4
`define ATSM_SEL2_MSB      3
`define ATSM_SEL2_LSB      0
`define ATSM_CONV_MSB      5
`define ATSM_CONV_LSB      0
`define ATSM_SMP_I_MSB     7
`define ATSM_SMP_I_LSB     4
`define ATSM_SMP_Q_MSB     3
`define ATSM_SMP_Q_LSB     0

// ***************************************************************
// Reset values
// ***************************************************************
`define ATSM_RST_SRC_SEL   8'h00
`define ATSM_RST_CONV      6'h00
`define ATSM_RST_PROD      8'hFF
`define ATSM_RST_SAMPLE    8'h00

// ***************************************************************
// Source selector codes
// ***************************************************************
`define ATSM_CODE_HIZ      4'h0
`define ATSM_CODE_CONV     4'h1
`define ATSM_CODE_CORR     4'h2
`define ATSM_CODE_RSV3     4'h3
`define ATSM_CODE_MINLVL   4'h4
`define ATSM_CODE_SMP_I    4'h5
`define ATSM_CODE_SMP_Q    4'h6
`define ATSM_CODE_RSV7     4'h7
`define ATSM_CODE_PROD     4'h8
`define ATSM_CODE_RSV9     4'h9
`define ATSM_CODE_HIGH     4'hA
`define ATSM_CODE_LOW      4'hB
`define ATSM_CODE_TXACT    4'hC
`define ATSM_CODE_RXACT    4'hD
`define ATSM_CODE_SUBC     4'hE
`define ATSM_CODE_TBUS     4'hF

`endif

// file: hdl/atsm_src_sel.v
/*
  Source selector for one auxiliary observation pin: decodes a 4-bit source
  code into a drive enable, a digital level and a converter code.
  Assumes all source signals come from logic on the same clock; purely
  combinational, the caller registers the outputs.
*/
`timescale 1ns/10ps
`include "atsm_regs.vh"

module atsm_src_sel (
  input  wire [3:0] code_in,
  input  wire [5:0] conv_val_in,
  input  wire       corr_in,
  input  wire [3:0] min_level_in,
  input  wire [3:0] smp_i_in,
  input  wire [3:0] smp_q_in,
  input  wire       tx_frame_in,
  input  wire       tx_data_in,
  input  wire       rx_frame_in,
  input  wire       rx_data_in,
  input  wire       subc_in,
  input  wire [7:0] test_bus_in,
  input  wire [2:0] bit_choice_in,
  input  wire       rate_106_in,
  output reg        drive_out,
  output reg        level_out,
  output reg        conv_en_out,
  output reg  [5:0] conv_code_out
);

  // ***************************************************************
  // Nibble scaling
  // ***************************************************************
  // Shared by three codes so the converter path scales them alike
  function [5:0] atsm_scale;
    input [3:0] nib;
    begin
      atsm_scale = {nib, 2'b00};
    end
  endfunction

  // ***************************************************************
  // Code decode
  // ***************************************************************
  // Nibble values are scaled to the top of the 6-bit converter range
  always @* begin
    drive_out     = 1'b0;
    level_out     = 1'b0;
    conv_en_out   = 1'b0;
    conv_code_out = 6'h00;
    case (code_in)
      `ATSM_CODE_HIZ: begin
        drive_out = 1'b0;
      end
      `ATSM_CODE_CONV: begin
        drive_out     = 1'b1;
        conv_en_out   = 1'b1;
        conv_code_out = conv_val_in;
      end
      `ATSM_CODE_CORR: begin
        drive_out = 1'b1;
        level_out = corr_in;
      end
      `ATSM_CODE_MINLVL: begin
        drive_out     = 1'b1;
        conv_en_out   = 1'b1;
        conv_code_out = atsm_scale(min_level_in);
      end
      `ATSM_CODE_SMP_I: begin
        drive_out     = 1'b1;
        conv_en_out   = 1'b1;
        conv_code_out = atsm_scale(smp_i_in);
      end
      `ATSM_CODE_SMP_Q: begin
        drive_out     = 1'b1;
        conv_en_out   = 1'b1;
        conv_code_out = atsm_scale(smp_q_in);
      end
      `ATSM_CODE_HIGH: begin
        drive_out = 1'b1;
        level_out = 1'b1;
      end
      `ATSM_CODE_LOW: begin
        drive_out = 1'b1;
        level_out = 1'b0;
      end
      `ATSM_CODE_TXACT: begin
        drive_out = 1'b1;
        level_out = rate_106_in ? tx_frame_in : tx_data_in;
      end
      `ATSM_CODE_RXACT: begin
        drive_out = 1'b1;
        level_out = rate_106_in ? rx_frame_in : rx_data_in;
      end
      `ATSM_CODE_SUBC: begin
        drive_out = 1'b1;
        level_out = rate_106_in ? 1'b0 : subc_in;
      end
      `ATSM_CODE_TBUS: begin
        drive_out = 1'b1;
        level_out = test_bus_in[bit_choice_in];
      end
      default: begin
        // Reserved and production codes leave the pin floating
        drive_out = 1'b0;
      end
    endcase
  end

endmodule

// file: hdl/atsm_top.v
/*
  Auxiliary test signal mux: source select, two test converter values,
  sample nibble readout and a production test register behind an
  Avalon-MM slave with waitrequest, plus the two observation pin drivers.
  Assumes every source signal and the rate code come from logic on
  clock_in, and that the pad cell resolves the pin from level and enable.
*/
// The Avalon-MM register port was chosen for this implementation.
// Notes on behaviour
// - Source code 0000 leaves the observation pin undriven.
// - Code 0001 drives each pin from its own test converter.
// - Code 0010 routes correlator signal; 0100 routes minimum level via converter.
// - Codes 0101 and 0110 present in-phase and quadrature samples via converter.
// - Codes 0011, 0111, 1000, 1001 are reserved; pin stays undriven.
// - Code 1010 drives constant high, 1011 constant low.
// - Code 1100 at 106 kBd: high over whole transmit frame.
// - Faster rates: activity selections high only during data and checksum.
// - Code 1101 at 106 kBd: high while data, parity, checksum received.
// - Code 1110 shows subcarrier detection; low at 106 kBd.
// - Code 1111 outputs one test bus bit picked by a 3-bit choice.
// - Second pin code sits in bits 3:0, same meanings as bits 7:4.
// - Source select register is read/write and resets to zero.
// - First converter value is 6 bits, reaches first pin on code 0001.
// - Second converter value is 6 bits, reaches second pin on code 0001.
// - Converter values have no meaningful reset; software writes them first.
// - Sample readout is read-only: in-phase nibble high, quadrature nibble low.
// - Production test register reads all ones and has no function.
`timescale 1ns/10ps
`include "atsm_regs.vh"

module atsm_top (
  input  wire        clock_in,
  input  wire        nrst_in,
  // Avalon-MM slave
  input  wire [7:0]  avs_address_in,
  input  wire        avs_read_in,
  input  wire        avs_write_in,
  input  wire [31:0] avs_writedata_in,
  input  wire [3:0]  avs_byteenable_in,
  output wire [31:0] avs_readdata_out,
  output wire        avs_waitrequest_out,
  // Internal sources
  input  wire        correlator_signal_one_in,
  input  wire [3:0]  minimum_level_threshold_in,
  input  wire [3:0]  sample_i_in,
  input  wire [3:0]  sample_q_in,
  input  wire        transmit_in_progress_in,
  input  wire        transmit_data_crc_in,
  input  wire        receive_in_progress_in,
  input  wire        receive_data_crc_in,
  input  wire        subcarrier_detected_in,
  input  wire [7:0]  test_bus_in,
  input  wire [2:0]  test_bus_bit_choice_in,
  input  wire        rate_106_in,
  // First observation pin
  output wire        first_observation_pin_out,
  output wire        first_observation_pin_oe_n_out,
  output wire        first_converter_en_out,
  output wire [5:0]  first_converter_code_out,
  // Second observation pin
  output wire        second_observation_pin_out,
  output wire        second_observation_pin_oe_n_out,
  output wire        second_converter_en_out,
  output wire [5:0]  second_converter_code_out
);

  // ***************************************************************
  // Declarations
  // ***************************************************************
  localparam [1:0] ST_IDLE = 2'b01;
  localparam [1:0] ST_ACK  = 2'b10;

  reg  [1:0]  bus_st_r;
  reg  [1:0]  bus_st_nxt;
  reg         wait_r;
  reg  [31:0] rdata_r;
  reg  [31:0] rdata_nxt;

  reg  [7:0]  src_sel_r;
  reg  [5:0]  conv1_r;
  reg  [5:0]  conv2_r;
  reg  [7:0]  sample_r;

  reg         pin1_r;
  reg         pin1_oe_n_r;
  reg         conv1_en_r;
  reg  [5:0]  conv1_code_r;
  reg         pin2_r;
  reg         pin2_oe_n_r;
  reg         conv2_en_r;
  reg  [5:0]  conv2_code_r;

  wire        req;
  wire        wr_commit;
  wire [3:0]  first_pin_source_code;
  wire [3:0]  second_pin_source_code;

  wire        sel1_drive;
  wire        sel1_level;
  wire        sel1_conv_en;
  wire [5:0]  sel1_conv_code;
  wire        sel2_drive;
  wire        sel2_level;
  wire        sel2_conv_en;
  wire [5:0]  sel2_conv_code;

  // ***************************************************************
  // Address decode helper
  // ***************************************************************
  // Matches one register word; low address bits must be zero
  function atsm_hit;
    input [7:0] addr;
    input [5:0] idx;
    begin
      atsm_hit = (addr == {idx, 2'b00});
    end
  endfunction

  // ***************************************************************
  // Bus handshake
  // ***************************************************************
  // Every access gets one wait state so read data come from a flop
  assign req       = avs_read_in | avs_write_in;
  assign wr_commit = (bus_st_r == ST_ACK) & avs_write_in & avs_byteenable_in[0];

  // Next state of the handshake
  always @* begin
    bus_st_nxt = bus_st_r;
    case (bus_st_r)
      ST_IDLE: begin
        if (req) begin
          bus_st_nxt = ST_ACK;
        end
      end
      ST_ACK: begin
        bus_st_nxt = ST_IDLE;
      end
      default: begin
        bus_st_nxt = ST_IDLE;
      end
    endcase
  end

  // Read mux; unmapped words read as zero
  always @* begin
    rdata_nxt = 32'h0000_0000;
    if (atsm_hit(avs_address_in, `ATSM_IDX_SRC_SEL)) begin
      rdata_nxt[7:0] = src_sel_r;
    end else if (atsm_hit(avs_address_in, `ATSM_IDX_CONV1)) begin
      rdata_nxt[7:0] = {2'b00, conv1_r};
    end else if (atsm_hit(avs_address_in, `ATSM_IDX_CONV2)) begin
      rdata_nxt[7:0] = {2'b00, conv2_r};
    end else if (atsm_hit(avs_address_in, `ATSM_IDX_SAMPLE)) begin
      rdata_nxt[7:0] = sample_r;
    end else if (atsm_hit(avs_address_in, `ATSM_IDX_PROD)) begin
      rdata_nxt[7:0] = `ATSM_RST_PROD;
    end
  end

  // Handshake state, wait flag and captured read data
  always @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      bus_st_r <= ST_IDLE;
      wait_r   <= 1'b1;
      rdata_r  <= 32'h0000_0000;
    end else begin
      bus_st_r <= bus_st_nxt;
      wait_r   <= ~(bus_st_r == ST_IDLE && req);
      if (bus_st_r == ST_IDLE && avs_read_in) begin
        rdata_r <= rdata_nxt;
      end
    end
  end

  assign avs_waitrequest_out = wait_r;
  assign avs_readdata_out    = rdata_r;

  // ***************************************************************
  // Register file
  // ***************************************************************
  // Source select resets to zero so both pins come up floating
  always @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      src_sel_r <= `ATSM_RST_SRC_SEL;
    end else if (wr_commit && atsm_hit(avs_address_in, `ATSM_IDX_SRC_SEL)) begin
      src_sel_r <= avs_writedata_in[7:0];
    end
  end

  // Converter values: cleared at reset only to keep the pins clean;
  // software must still load them before selecting code 0001
  always @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      conv1_r <= `ATSM_RST_CONV;
      conv2_r <= `ATSM_RST_CONV;
    end else begin
      if (wr_commit && atsm_hit(avs_address_in, `ATSM_IDX_CONV1)) begin
        conv1_r <= avs_writedata_in[`ATSM_CONV_MSB:`ATSM_CONV_LSB];
      end
      if (wr_commit && atsm_hit(avs_address_in, `ATSM_IDX_CONV2)) begin
        conv2_r <= avs_writedata_in[`ATSM_CONV_MSB:`ATSM_CONV_LSB];
      end
    end
  end

  // Sample snapshot, refreshed every cycle; writes have no effect
  always @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      sample_r <= `ATSM_RST_SAMPLE;
    end else begin
      sample_r[`ATSM_SMP_I_MSB:`ATSM_SMP_I_LSB] <= sample_i_in;
      sample_r[`ATSM_SMP_Q_MSB:`ATSM_SMP_Q_LSB] <= sample_q_in;
    end
  end

  // ***************************************************************
  // Source selection for both pins
  // ***************************************************************
  // Same decoder on both nibbles keeps the code meanings identical
  assign first_pin_source_code  = src_sel_r[`ATSM_SEL1_MSB:`ATSM_SEL1_LSB];
  assign second_pin_source_code = src_sel_r[`ATSM_SEL2_MSB:`ATSM_SEL2_LSB];

  atsm_src_sel u_sel1 (
    .code_in       (first_pin_source_code),
    .conv_val_in   (conv1_r),
    .corr_in       (correlator_signal_one_in),
    .min_level_in  (minimum_level_threshold_in),
    .smp_i_in      (sample_i_in),
    .smp_q_in      (sample_q_in),
    .tx_frame_in   (transmit_in_progress_in),
    .tx_data_in    (transmit_data_crc_in),
    .rx_frame_in   (receive_in_progress_in),
    .rx_data_in    (receive_data_crc_in),
    .subc_in       (subcarrier_detected_in),
    .test_bus_in   (test_bus_in),
    .bit_choice_in (test_bus_bit_choice_in),
    .rate_106_in   (rate_106_in),
    .drive_out     (sel1_drive),
    .level_out     (sel1_level),
    .conv_en_out   (sel1_conv_en),
    .conv_code_out (sel1_conv_code)
  );

  atsm_src_sel u_sel2 (
    .code_in       (second_pin_source_code),
    .conv_val_in   (conv2_r),
    .corr_in       (correlator_signal_one_in),
    .min_level_in  (minimum_level_threshold_in),
    .smp_i_in      (sample_i_in),
    .smp_q_in      (sample_q_in),
    .tx_frame_in   (transmit_in_progress_in),
    .tx_data_in    (transmit_data_crc_in),
    .rx_frame_in   (receive_in_progress_in),
    .rx_data_in    (receive_data_crc_in),
    .subc_in       (subcarrier_detected_in),
    .test_bus_in   (test_bus_in),
    .bit_choice_in (test_bus_bit_choice_in),
    .rate_106_in   (rate_106_in),
    .drive_out     (sel2_drive),
    .level_out     (sel2_level),
    .conv_en_out   (sel2_conv_en),
    .conv_code_out (sel2_conv_code)
  );

  // ***************************************************************
  // Pin output registers
  // ***************************************************************
  // One cycle of latency is traded for glitch-free pad drive
  always @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      pin1_r       <= 1'b0;
      pin1_oe_n_r  <= 1'b1;
      conv1_en_r   <= 1'b0;
      conv1_code_r <= 6'h00;
      pin2_r       <= 1'b0;
      pin2_oe_n_r  <= 1'b1;
      conv2_en_r   <= 1'b0;
      conv2_code_r <= 6'h00;
    end else begin
      pin1_r       <= sel1_level;
      pin1_oe_n_r  <= ~sel1_drive;
      conv1_en_r   <= sel1_conv_en;
      conv1_code_r <= sel1_conv_code;
      pin2_r       <= sel2_level;
      pin2_oe_n_r  <= ~sel2_drive;
      conv2_en_r   <= sel2_conv_en;
      conv2_code_r <= sel2_conv_code;
    end
  end

  assign first_observation_pin_out       = pin1_r;
  assign first_observation_pin_oe_n_out  = pin1_oe_n_r;
  assign first_converter_en_out          = conv1_en_r;
  assign first_converter_code_out        = conv1_code_r;
  assign second_observation_pin_out      = pin2_r;
  assign second_observation_pin_oe_n_out = pin2_oe_n_r;
  assign second_converter_en_out         = conv2_en_r;
  assign second_converter_code_out       = conv2_code_r;

endmodule

// file: test/atsm_exp.svh
/* Expected pin state {oe_n, level, conv_en, code} for one source code.
   Included inside a module body; s packs the source inputs, rate at 29. */
// ********
// Pin model
// ********
function automatic logic [8:0] atsm_exp(input logic [3:0] c, input logic [5:0] cv,
                                        input logic [29:0] s);
  case (c)
    4'h1: return {3'b001, cv};
    4'h2: return {1'b0, s[0], 7'h00};
    4'h4: return {3'b001, s[4:1], 2'b00};
    4'h5: return {3'b001, s[8:5], 2'b00};
    4'h6: return {3'b001, s[12:9], 2'b00};
    4'hA: return 9'h080;
    4'hB: return 9'h000;
    4'hC: return {1'b0, s[29] ? s[13] : s[14], 7'h00};
    4'hD: return {1'b0, s[29] ? s[15] : s[16], 7'h00};
    4'hE: return {1'b0, !s[29] && s[17], 7'h00};
    4'hF: return {1'b0, s[18 + s[28:26]], 7'h00};
    // Reserved and production codes stay undriven
    default: return 9'h100;
  endcase
endfunction

// file: test/atsm_top_assertions.sv
/* Assertions for atsm_top, bound at the foot of this file.
   Sees only its ports; shadows the writable registers from accepted writes. */
`timescale 1ns/10ps
module atsm_chk (
  input logic        clock_in,
  input logic        nrst_in,
  input logic        avs_read_in,
  input logic        avs_write_in,
  input logic        avs_waitrequest_out,
  input logic [7:0]  avs_address_in,
  input logic [7:0]  test_bus_in,
  input logic [31:0] avs_writedata_in,
  input logic [31:0] avs_readdata_out,
  input logic [3:0]  avs_byteenable_in,
  input logic [3:0]  minimum_level_threshold_in,
  input logic [3:0]  sample_i_in,
  input logic [3:0]  sample_q_in,
  input logic        correlator_signal_one_in,
  input logic        transmit_in_progress_in,
  input logic        transmit_data_crc_in,
  input logic        receive_in_progress_in,
  input logic        receive_data_crc_in,
  input logic        subcarrier_detected_in,
  input logic [2:0]  test_bus_bit_choice_in,
  input logic        rate_106_in,
  input logic        first_observation_pin_out,
  input logic        first_observation_pin_oe_n_out,
  input logic        first_converter_en_out,
  input logic        second_observation_pin_out,
  input logic        second_observation_pin_oe_n_out,
  input logic        second_converter_en_out,
  input logic [5:0]  first_converter_code_out,
  input logic [5:0]  second_converter_code_out
);
  `include "atsm_exp.svh"
  logic [7:0] sel_r;
  logic [5:0] cv1_r, cv2_r;
  logic [8:0] e1_r, e2_r;
  wire  [29:0] src = {rate_106_in, test_bus_bit_choice_in, test_bus_in,
    subcarrier_detected_in, receive_data_crc_in, receive_in_progress_in,
    transmit_data_crc_in, transmit_in_progress_in, sample_q_in, sample_i_in,
    minimum_level_threshold_in, correlator_signal_one_in};
  wire wr_ok = avs_write_in && !avs_waitrequest_out && avs_byteenable_in[0];
  wire rd_ok = avs_read_in && !avs_waitrequest_out;
  wire [8:0] p1 = {first_observation_pin_oe_n_out, first_observation_pin_out,
    first_converter_en_out, first_converter_code_out};
  wire [8:0] p2 = {second_observation_pin_oe_n_out, second_observation_pin_out,
    second_converter_en_out, second_converter_code_out};

  // Shadow registers and next pin state; writes land at the accepting edge
  always @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      sel_r <= 8'h00;
      cv1_r <= 6'h00;
      cv2_r <= 6'h00;
      e1_r  <= 9'h100;
      e2_r  <= 9'h100;
    end else begin
      if (wr_ok && avs_address_in == 8'hE0) sel_r <= avs_writedata_in[7:0];
      if (wr_ok && avs_address_in == 8'hE4) cv1_r <= avs_writedata_in[5:0];
      if (wr_ok && avs_address_in == 8'hE8) cv2_r <= avs_writedata_in[5:0];
      e1_r <= atsm_exp(sel_r[7:4], cv1_r, src);
      e2_r <= atsm_exp(sel_r[3:0], cv2_r, src);
    end
  end

  // ********
  // Checks
  // ********
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!nrst_in);
  a_first_pin_map:
    assert property (p1 == e1_r) else $error("first pin differs from its source");
  a_second_pin_map:
    assert property (p2 == e2_r) else $error("second pin differs from its source");
  a_hiz_no_drive:
    assert property (sel_r[3:0] == 4'h0 |=> p2[8] && !p2[6])
    else $error("second pin driven with code zero");
  a_wait_one_cycle:
    assert property ($rose(avs_read_in || avs_write_in) |-> avs_waitrequest_out
      ##1 !avs_waitrequest_out ##1 avs_waitrequest_out) else $error("bad wait states");
  a_idle_wait_high:
    assert property (!(avs_read_in || avs_write_in) |=> avs_waitrequest_out)
    else $error("waitrequest low while idle");
  a_select_readback:
    assert property (rd_ok && avs_address_in == 8'hE0 |->
      avs_readdata_out == {24'h00_0000, sel_r}) else $error("select readback wrong");
  a_conv_rsvd_zero:
    assert property (rd_ok && avs_address_in inside {8'hE4, 8'hE8} |->
      avs_readdata_out[31:6] == 26'h000_0000) else $error("converter reserved bits set");
  a_prod_all_ones:
    assert property (rd_ok && avs_address_in == 8'hF0 |->
      avs_readdata_out == 32'h0000_00FF) else $error("production register not all ones");
  a_sample_upper_zero:
    assert property (rd_ok && avs_address_in == 8'hEC |->
      avs_readdata_out[31:8] == 24'h00_0000) else $error("sample readout upper bits set");
endmodule

bind atsm_top atsm_chk chk (
  .clock_in, .nrst_in, .avs_read_in, .avs_write_in, .avs_waitrequest_out, .avs_address_in,
  .test_bus_in, .avs_writedata_in, .avs_readdata_out, .avs_byteenable_in,
  .minimum_level_threshold_in, .sample_i_in, .sample_q_in, .correlator_signal_one_in,
  .transmit_in_progress_in, .transmit_data_crc_in, .receive_in_progress_in,
  .receive_data_crc_in, .subcarrier_detected_in, .test_bus_bit_choice_in, .rate_106_in,
  .first_observation_pin_out, .first_observation_pin_oe_n_out, .first_converter_en_out,
  .second_observation_pin_out, .second_observation_pin_oe_n_out, .second_converter_en_out,
  .first_converter_code_out, .second_converter_code_out
);

// file: test/tb_aux_test_signal_mux.sv
/* Self-checking bench for atsm_top: Avalon-MM register access, all codes
   on both pins at both rates, reset in mid-run. Checker binds itself. */
`timescale 1ns/10ps
module tb_aux_test_signal_mux;
  `include "atsm_exp.svh"
  logic        clock_in = 1'b0;
  logic        nrst_in  = 1'b0;
  logic        rd       = 1'b0;
  logic        wr       = 1'b0;
  logic [7:0]  addr     = 8'h00;
  logic [3:0]  ben      = 4'hF;
  logic [31:0] wdata    = 32'h0000_0000;
  logic [29:0] src      = 30'h0000_0000;
  logic [5:0]  v1, v2;
  wire  [31:0] rdata;
  wire         wreq;
  wire  [8:0]  p1, p2;
  int          fails = 0;
  int          total_checks = 0;

  // 25 MHz clock
  always #20 clock_in = ~clock_in;

  atsm_top dut (
    .clock_in(clock_in), .nrst_in(nrst_in), .avs_address_in(addr), .avs_read_in(rd),
    .avs_write_in(wr), .avs_writedata_in(wdata), .avs_byteenable_in(ben),
    .avs_readdata_out(rdata), .avs_waitrequest_out(wreq),
    .correlator_signal_one_in(src[0]), .minimum_level_threshold_in(src[4:1]),
    .sample_i_in(src[8:5]), .sample_q_in(src[12:9]), .transmit_in_progress_in(src[13]),
    .transmit_data_crc_in(src[14]), .receive_in_progress_in(src[15]),
    .receive_data_crc_in(src[16]), .subcarrier_detected_in(src[17]),
    .test_bus_in(src[25:18]), .test_bus_bit_choice_in(src[28:26]), .rate_106_in(src[29]),
    .first_observation_pin_out(p1[7]), .first_observation_pin_oe_n_out(p1[8]),
    .first_converter_en_out(p1[6]), .first_converter_code_out(p1[5:0]),
    .second_observation_pin_out(p2[7]), .second_observation_pin_oe_n_out(p2[8]),
    .second_converter_en_out(p2[6]), .second_converter_code_out(p2[5:0])
  );

  // ********
  // Tasks
  // ********
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // One access; held until waitrequest is sampled low, bounded wait
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic [3:0] be, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clock_in);
    rd <= !w;
    wr <= w;
    addr <= a;
    wdata <= d;
    ben <= be;
    do begin
      @(posedge clock_in);
      n++;
    end while (wreq !== 1'b0 && n < 20);
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
    if (wreq !== 1'b0) begin
      fails++;
      finish_test();
    end
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, 4'hF, q);
  endtask

  task automatic rd_chk(input string nm, input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0000_0000, 4'hF, q);
    check(nm, q, e);
  endtask

  // Expected pin state from the sources currently applied
  function automatic logic [8:0] pin_exp(input logic [3:0] c, input logic [5:0] cv);
    return atsm_exp(c, cv, src);
  endfunction

  // Main sequence
  initial begin
    logic [31:0] q;
    void'($urandom(32'hf5404ef7));
    repeat (10) @(posedge clock_in);
    nrst_in <= 1'b1;
    rd_chk("select reset", 8'hE0, 32'h0000_0000);
    rd_chk("production", 8'hF0, 32'h0000_00FF);
    check("oe_n reset", {p2[8], p1[8]}, 32'h0000_0003);
    $display("reset test done");
    // Reserved bits set on purpose; masked write, read-only and unmapped writes
    v1 = 6'($urandom);
    v2 = 6'($urandom);
    wr_reg(8'hE4, 32'hFFFF_FFC0 | v1);
    wr_reg(8'hE8, 32'hFFFF_FFC0 | v2);
    bus(1'b1, 8'hE4, 32'h0000_0000, 4'h0, q);
    wr_reg(8'hEC, 32'h0000_0000);
    wr_reg(8'hF0, 32'h0000_0000);
    wr_reg(8'hF4, 32'h0000_00FF);
    rd_chk("conv1", 8'hE4, v1);
    rd_chk("conv2", 8'hE8, v2);
    rd_chk("production", 8'hF0, 32'h0000_00FF);
    rd_chk("unmapped", 8'hF4, 32'h0000_0000);
    $display("register test done");
    @(posedge clock_in);
    src <= 30'($urandom);
    repeat (2) @(posedge clock_in);
    rd_chk("sample", 8'hEC, {src[8:5], src[12:9]});
    $display("sample test done");
    // Every code on both pins, second pin gets the inverted code
    for (int r = 0; r < 2; r++) begin
      for (int c = 0; c < 16; c++) begin
        @(posedge clock_in);
        src <= {r[0], 29'($urandom)};
        wr_reg(8'hE0, {c[3:0], ~c[3:0]});
        repeat (2) @(posedge clock_in);
        check("pin1", p1, pin_exp(c[3:0], v1));
        check("second pin", p2, pin_exp(~c[3:0], v2));
      end
    end
    rd_chk("select", 8'hE0, 32'h0000_00F0);
    $display("source code test done");
    @(posedge clock_in);
    nrst_in <= 1'b0;
    repeat (2) @(posedge clock_in);
    check("oe_n in reset", {p2[8], p1[8]}, 32'h0000_0003);
    nrst_in <= 1'b1;
    rd_chk("select after reset", 8'hE0, 32'h0000_0000);
    check("oe_n after reset", {p2[8], p1[8]}, 32'h0000_0003);
    $display("mid-run reset test done");
    finish_test();
  end
endmodule
